// file: hw/ssuc_top.sv
// What this block does
// - Start subtask on mode change, selected start input, or either, per start setting.
// - Start input chosen from X0..X67 and X372..X377 on the large model.
// - Stop subtask on mode change only, or also on the selected stop input.
// - Drive selected error output on subtask error only when error output enabled.
// - Changeover 0 ignores inputs; step flag alone picks step or cycle operation.
// - Changeover 1 picks step when selected input or step flag is on.
// - Unit setting picks mechanical, motor pulses (reset value) or combined basis.
// - Pulse rate and feed rate used only for unit settings 0 and 2.
// - Positions in units for 0 and 2, pulses for 1; speed Hz for 1 and 2.
// - Interpolation uses X axis pulse rate and feed rate only.
// - Two-axis mode uses X axis settings and ignores Y axis settings.
// - Pulses equal pulse rate times travel over feed rate times ten to minus three.
// - Stop input same ranges; small model limited to X0..X3 and X375..X377.
// - Pulse rate is pulses per motor revolution, from 1 to 65535.
`timescale 1ns/1ps
`default_nettype none
`include "ssuc_consts.svh"
module ssuc_top #(
  parameter int IN_W = 62,
  parameter int OUT_W = 56,
  parameter bit LARGE_MODEL = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire ssuc_pkg::ssuc_word_t pwdata_i,
  output ssuc_pkg::ssuc_word_t prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Machine side
  input wire logic [IN_W-1:0] x_in_i,
  input wire logic auto_mode_i,
  input wire logic subtask_error_i,
  output logic [OUT_W-1:0] y_out_o,
  output logic subtask_run_o,
  output logic step_mode_o,
  output logic irq_o
);
  import ssuc_pkg::*;

  // ----------------------------------------
  // Input selection
  // ----------------------------------------
  // Out-of-range codes select nothing rather than aliasing onto a real input
  function automatic logic sel_bit(input logic [IN_W-1:0] vec, input logic [5:0] idx);
    logic ok;
    ok = 1'b0;
    if (LARGE_MODEL) begin
      ok = (idx <= `SSUC_IN_HIGH_LAST);
    end else begin
      ok = (idx <= `SSUC_IN_SMALL_LAST) ||
           ((idx >= `SSUC_IN_SMALL_HIGH) && (idx <= `SSUC_IN_HIGH_LAST));
    end
    sel_bit = ok && vec[idx];
  endfunction

  logic [6:0] cfg_reg;
  logic [5:0] start_sel_reg;
  logic [5:0] stop_sel_reg;
  logic [5:0] chg_sel_reg;
  logic [5:0] err_sel_reg;
  logic [15:0] pulse_rate_reg;
  logic [19:0] feed_rate_reg;
  logic [31:0] travel_reg;
  logic step_flag_reg;
  logic [3:0] int_stat_reg;
  logic [3:0] int_mask_reg;

  wire [1:0] start_mode = cfg_reg[`SSUC_CFG_START_HI:`SSUC_CFG_START_LO];
  wire stop_mode = cfg_reg[`SSUC_CFG_STOP];
  wire err_en = cfg_reg[`SSUC_CFG_ERR_EN];
  wire chg_mode = cfg_reg[`SSUC_CFG_CHG];
  wire [1:0] unit_sys = cfg_reg[`SSUC_CFG_UNIT_HI:`SSUC_CFG_UNIT_LO];

  wire start_lvl = sel_bit(x_in_i, start_sel_reg);
  wire stop_lvl = sel_bit(x_in_i, stop_sel_reg);
  wire chg_lvl = sel_bit(x_in_i, chg_sel_reg);

  // ----------------------------------------
  // Subtask start and stop
  // ----------------------------------------
  logic start_prev_reg;
  logic stop_prev_reg;
  logic auto_prev_reg;
  logic run_reg;
  logic err_out_reg;
  logic step_reg;
  wire start_edge = start_lvl && !start_prev_reg;
  wire stop_edge = stop_lvl && !stop_prev_reg;
  wire to_auto = auto_mode_i && !auto_prev_reg;
  wire start_req = ((start_mode == `SSUC_START_MODE) && to_auto) ||
                   ((start_mode == `SSUC_START_INPUT) && auto_mode_i && start_edge) ||
                   ((start_mode == `SSUC_START_BOTH) &&
                    (to_auto || (auto_mode_i && start_edge)));
  wire stop_req = to_auto || (stop_mode && stop_edge);
  // A start in the same cycle as a stop restarts the subtask
  wire run_next = start_req ? 1'b1 : (stop_req ? 1'b0 : run_reg);
  wire err_evt = subtask_error_i && run_reg;
  wire err_out_next = err_en && (err_evt || (err_out_reg && !start_req));
  wire step_next = chg_mode ? (chg_lvl || step_flag_reg) : step_flag_reg;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      start_prev_reg <= 1'b0;
      stop_prev_reg <= 1'b0;
      auto_prev_reg <= 1'b0;
      run_reg <= 1'b0;
      err_out_reg <= 1'b0;
      step_reg <= 1'b0;
    end else begin
      start_prev_reg <= start_lvl;
      stop_prev_reg <= stop_lvl;
      auto_prev_reg <= auto_mode_i;
      run_reg <= run_next;
      err_out_reg <= err_out_next;
      step_reg <= step_next;
    end
  end

  // Error output mapped onto the chosen Y point
  logic [OUT_W-1:0] y_out_reg;
  wire err_sel_ok = LARGE_MODEL ? (err_sel_reg <= `SSUC_OUT_LAST) :
                                  (err_sel_reg <= `SSUC_OUT_SMALL_LAST);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      y_out_reg <= '0;
    end else begin
      y_out_reg <= '0;
      if (err_out_next && err_sel_ok) begin
        y_out_reg[err_sel_reg] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Travel to pulse conversion
  // ----------------------------------------
  // Only one axis parameter set exists; interpolation and two-axis use it
  logic [57:0] quot_reg;
  logic [20:0] rem_reg;
  logic [5:0] step_cnt_reg;
  ssuc_div_state_t div_state_reg;
  logic conv_done_pulse;
  logic apb_wr;
  logic travel_wr;
  wire mech_basis = (unit_sys != `SSUC_UNIT_MOTOR);
  // Feed rate is in thousandths, hence the factor on the dividend
  wire [57:0] dividend = 58'(pulse_rate_reg) * 58'(pwdata_i) * 58'(`SSUC_MILLI);
  wire [20:0] rem_sh = {rem_reg[19:0], quot_reg[57]};
  wire rem_ge = (rem_sh >= {1'b0, feed_rate_reg});
  wire [20:0] rem_sub = rem_sh - {1'b0, feed_rate_reg};

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      quot_reg <= '0;
      rem_reg <= '0;
      step_cnt_reg <= '0;
      div_state_reg <= SSUC_IDLE;
      conv_done_pulse <= 1'b0;
    end else begin
      conv_done_pulse <= 1'b0;
      unique case (div_state_reg)
        SSUC_IDLE: begin
          if (travel_wr) begin
            rem_reg <= '0;
            step_cnt_reg <= '0;
            if (mech_basis) begin
              quot_reg <= dividend;
              div_state_reg <= SSUC_CALC;
            end else begin
              quot_reg <= {26'h0, pwdata_i};
              conv_done_pulse <= 1'b1;
            end
          end
        end
        SSUC_CALC: begin
          quot_reg <= {quot_reg[56:0], rem_ge};
          rem_reg <= rem_ge ? rem_sub : rem_sh;
          step_cnt_reg <= step_cnt_reg + 6'h01;
          if (step_cnt_reg == `SSUC_DIV_STEPS - 6'h01) begin
            div_state_reg <= SSUC_IDLE;
            conv_done_pulse <= 1'b1;
          end
        end
      endcase
    end
  end
  wire conv_busy = (div_state_reg == SSUC_CALC);
  wire conv_ovf = |quot_reg[57:32];

  // ----------------------------------------
  // APB register file
  // ----------------------------------------
  logic pready_reg;
  logic pslverr_reg;
  ssuc_word_t prdata_reg;
  wire access = psel_i && penable_i && !pready_reg;
  wire hit_cfg = (paddr_i == `SSUC_OFF_CFG);
  wire hit_start = (paddr_i == `SSUC_OFF_START_SEL);
  wire hit_stop = (paddr_i == `SSUC_OFF_STOP_SEL);
  wire hit_chg = (paddr_i == `SSUC_OFF_CHG_SEL);
  wire hit_err = (paddr_i == `SSUC_OFF_ERR_SEL);
  wire hit_prate = (paddr_i == `SSUC_OFF_PULSE_RATE);
  wire hit_frate = (paddr_i == `SSUC_OFF_FEED_RATE);
  wire hit_travel = (paddr_i == `SSUC_OFF_TRAVEL);
  wire hit_pulses = (paddr_i == `SSUC_OFF_PULSES);
  wire hit_ctrl = (paddr_i == `SSUC_OFF_CTRL);
  wire hit_status = (paddr_i == `SSUC_OFF_STATUS);
  wire hit_istat = (paddr_i == `SSUC_OFF_INT_STAT);
  wire hit_imask = (paddr_i == `SSUC_OFF_INT_MASK);
  wire hit_any = hit_cfg | hit_start | hit_stop | hit_chg | hit_err | hit_prate |
                 hit_frate | hit_travel | hit_pulses | hit_ctrl | hit_status |
                 hit_istat | hit_imask;
  // Parameter writes during a conversion would corrupt it, so they are refused
  wire wr_lock = conv_busy && (hit_prate || hit_frate || hit_travel || hit_cfg);
  wire wr_err = pwrite_i && wr_lock;
  assign apb_wr = psel_i && penable_i && pready_reg && pwrite_i && hit_any && !wr_lock;
  assign travel_wr = apb_wr && hit_travel;
  // A zero pulse rate is out of range and replaced by the minimum
  wire [15:0] prate_wr = (pwdata_i[15:0] == 16'h0000) ? `SSUC_PULSE_RATE_RESET :
                         pwdata_i[15:0];
  wire [19:0] frate_wr = (pwdata_i[19:0] == 20'h00000) ? `SSUC_FEED_RATE_RESET :
                         pwdata_i[19:0];
  wire [3:0] evt = {conv_done_pulse, err_evt, stop_req && run_reg, start_req};
  wire [3:0] w1c = (apb_wr && hit_istat) ? pwdata_i[3:0] : 4'h0;
  wire [3:0] int_stat_next = evt | (int_stat_reg & ~w1c);
  wire [6:0] status_word = {conv_ovf, conv_busy, mech_basis, unit_sys != `SSUC_UNIT_MECH,
                            unit_sys == `SSUC_UNIT_MOTOR, step_reg, run_reg};
  ssuc_word_t rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit_cfg) rd_mux = {25'h0, cfg_reg};
    if (hit_start) rd_mux = {26'h0, start_sel_reg};
    if (hit_stop) rd_mux = {26'h0, stop_sel_reg};
    if (hit_chg) rd_mux = {26'h0, chg_sel_reg};
    if (hit_err) rd_mux = {26'h0, err_sel_reg};
    if (hit_prate) rd_mux = {16'h0, pulse_rate_reg};
    if (hit_frate) rd_mux = {12'h0, feed_rate_reg};
    if (hit_travel) rd_mux = travel_reg;
    if (hit_pulses) rd_mux = quot_reg[31:0];
    if (hit_ctrl) rd_mux = {31'h0, step_flag_reg};
    if (hit_status) rd_mux = {25'h0, status_word};
    if (hit_istat) rd_mux = {28'h0, int_stat_reg};
    if (hit_imask) rd_mux = {28'h0, int_mask_reg};
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access && (!hit_any || wr_err);
      prdata_reg <= (access && !pwrite_i) ? rd_mux : '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_reg <= `SSUC_CFG_RESET;
      start_sel_reg <= '0;
      stop_sel_reg <= '0;
      chg_sel_reg <= '0;
      err_sel_reg <= '0;
      pulse_rate_reg <= `SSUC_PULSE_RATE_RESET;
      feed_rate_reg <= `SSUC_FEED_RATE_RESET;
      travel_reg <= '0;
      step_flag_reg <= 1'b0;
      int_mask_reg <= '0;
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= int_stat_next;
      if (apb_wr && hit_cfg) cfg_reg <= pwdata_i[6:0];
      if (apb_wr && hit_start) start_sel_reg <= pwdata_i[5:0];
      if (apb_wr && hit_stop) stop_sel_reg <= pwdata_i[5:0];
      if (apb_wr && hit_chg) chg_sel_reg <= pwdata_i[5:0];
      if (apb_wr && hit_err) err_sel_reg <= pwdata_i[5:0];
      if (apb_wr && hit_prate) pulse_rate_reg <= prate_wr;
      if (apb_wr && hit_frate) feed_rate_reg <= frate_wr;
      if (travel_wr) travel_reg <= pwdata_i;
      if (apb_wr && hit_ctrl) step_flag_reg <= pwdata_i[0];
      if (apb_wr && hit_imask) int_mask_reg <= pwdata_i[3:0];
    end
  end

  logic irq_reg;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(int_stat_next & int_mask_reg);
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign y_out_o = y_out_reg;
  assign subtask_run_o = run_reg;
  assign step_mode_o = step_reg;
  assign irq_o = irq_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  mode_start_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_mode == `SSUC_START_MODE || start_mode == `SSUC_START_BOTH) &&
    auto_mode_i && !$past(auto_mode_i) |=> run_reg)
    else $error("subtask did not start on change to auto");
  input_start_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_mode == `SSUC_START_INPUT) && !auto_mode_i && !run_reg |=> !run_reg)
    else $error("input start acted outside auto mode");
  stop_mode_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !stop_mode && run_reg && !to_auto |=> run_reg)
    else $error("subtask stopped without mode change");
  stop_input_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    stop_mode && stop_edge && !start_req |=> !run_reg)
    else $error("stop input ignored");
  err_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !err_en |=> y_out_reg == '0)
    else $error("error output driven while disabled");
  err_on_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    err_en && err_evt && err_sel_ok |=> y_out_reg[$past(err_sel_reg)])
    else $error("error output missing");
  step_sel_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !chg_mode |=> step_reg == $past(step_flag_reg))
    else $error("step mode not following flag");
  held_input_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    start_lvl && $past(start_lvl) |-> !start_edge)
    else $error("held start input retriggered");
  motor_pass_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    travel_wr && !mech_basis && !conv_busy |=> conv_done_pulse && quot_reg[31:0] == $past(pwdata_i))
    else $error("motor units not passed through");
  conv_time_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    travel_wr && mech_basis && !conv_busy |=>
    conv_busy [*8] ##50 conv_busy ##1 conv_done_pulse)
    else $error("conversion length wrong");
endmodule // ssuc_top
`default_nettype wire

// file: hw/ssuc_consts.svh
`ifndef SSUC_CONSTS_SVH
`define SSUC_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SSUC_OFF_CFG 12'h000
`define SSUC_OFF_START_SEL 12'h004
`define SSUC_OFF_STOP_SEL 12'h008
`define SSUC_OFF_CHG_SEL 12'h00C
`define SSUC_OFF_ERR_SEL 12'h010
`define SSUC_OFF_PULSE_RATE 12'h014
`define SSUC_OFF_FEED_RATE 12'h018
`define SSUC_OFF_TRAVEL 12'h01C
`define SSUC_OFF_PULSES 12'h020
`define SSUC_OFF_CTRL 12'h024
`define SSUC_OFF_STATUS 12'h028
`define SSUC_OFF_INT_STAT 12'h02C
`define SSUC_OFF_INT_MASK 12'h030
// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define SSUC_CFG_START_LO 0
`define SSUC_CFG_START_HI 1
`define SSUC_CFG_STOP 2
`define SSUC_CFG_ERR_EN 3
`define SSUC_CFG_CHG 4
`define SSUC_CFG_UNIT_LO 5
`define SSUC_CFG_UNIT_HI 6
`define SSUC_CFG_RESET 7'h20
// ----------------------------------------
// Encodings
// ----------------------------------------
`define SSUC_START_MODE 2'h0
`define SSUC_START_INPUT 2'h1
`define SSUC_START_BOTH 2'h2
`define SSUC_UNIT_MECH 2'h0
`define SSUC_UNIT_MOTOR 2'h1
`define SSUC_UNIT_COMB 2'h2
// Input indices: 0..55 are X0..X67, 56..61 are X372..X377
`define SSUC_IN_LOW_LAST 6'h37
`define SSUC_IN_HIGH_FIRST 6'h38
`define SSUC_IN_HIGH_LAST 6'h3D
`define SSUC_IN_SMALL_LAST 6'h03
`define SSUC_IN_SMALL_HIGH 6'h3B
`define SSUC_OUT_LAST 6'h37
`define SSUC_OUT_SMALL_LAST 6'h05
// ----------------------------------------
// Interrupt bits and conversion
// ----------------------------------------
`define SSUC_IRQ_START 0
`define SSUC_IRQ_STOP 1
`define SSUC_IRQ_ERR 2
`define SSUC_IRQ_CONV 3
`define SSUC_MILLI 10'h3E8
`define SSUC_PULSE_RATE_RESET 16'h0001
`define SSUC_FEED_RATE_RESET 20'h00001
`define SSUC_DIV_STEPS 6'h3A
`endif

// file: hw/ssuc_pkg.sv
`default_nettype none
package ssuc_pkg;
  typedef enum logic [0:0] {SSUC_IDLE, SSUC_CALC} ssuc_div_state_t;
  typedef logic [31:0] ssuc_word_t;
endpackage
`default_nettype wire

// file: tb/ssuc_machine_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssuc_machine_model (
  // Clock
  input wire logic clk_sys_i,
  // Machine signals toward the unit
  output logic [61:0] x_in_o,
  output logic auto_mode_o,
  output logic subtask_error_o
);
  initial begin
    x_in_o = '0;
    auto_mode_o = 1'b0;
    subtask_error_o = 1'b0;
  end
  // Levels change only just after an edge, like a real input module
  task automatic set_x(input int idx, input logic lvl);
    @(posedge clk_sys_i);
    x_in_o[idx] <= lvl;
  endtask
  task automatic set_auto(input logic lvl);
    @(posedge clk_sys_i);
    auto_mode_o <= lvl;
  endtask
  task automatic err_pulse();
    @(posedge clk_sys_i);
    subtask_error_o <= 1'b1;
    @(posedge clk_sys_i);
    subtask_error_o <= 1'b0;
  endtask
endmodule // ssuc_machine_model
`default_nettype wire

// file: tb/test_subtask_sequencer_unit_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_subtask_sequencer_unit_config;
  import ssuc_pkg::*;
  logic clk_sys_i, rst_i, psel, penable, pwrite, pready, pslverr, irq, run, step;
  logic auto_mode, serr;
  logic [11:0] paddr;
  ssuc_word_t pwdata, prdata, rd;
  logic [61:0] x_in;
  logic [55:0] y_out;
  logic e;
  int errors = 0;
  int n_checks = 0;

  ssuc_top u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .x_in_i(x_in), .auto_mode_i(auto_mode),
    .subtask_error_i(serr), .y_out_o(y_out), .subtask_run_o(run), .step_mode_o(step),
    .irq_o(irq));
  ssuc_machine_model u_mach (.clk_sys_i(clk_sys_i), .x_in_o(x_in), .auto_mode_o(auto_mode),
    .subtask_error_o(serr));

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Samples pready at the edge itself, before that edge's updates land
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    apb(1'b0, 12'h000, 32'h0);
    check("cfg", rd, 32'h0000_0020);
    apb(1'b0, 12'h028, 32'h0);
    check("status", rd & 32'h1C, 32'h0000_000C);
    apb(1'b1, 12'h014, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    check("pulse rate min", rd, 32'h0000_0001);
    apb(1'b0, 12'h0F0, 32'h0);
    check("unmapped err", {31'h0, e}, 32'h1);
    $display("Done reset");
  endtask
  task automatic t_start_stop();
    apb(1'b1, 12'h030, 32'h1);
    u_mach.set_auto(1'b1);
    settle(3);
    check("run on mode", {31'h0, run}, 32'h1);
    check("irq start", {31'h0, irq}, 32'h1);
    apb(1'b1, 12'h02C, 32'h1);
    settle(2);
    check("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b1, 12'h000, 32'h25);
    apb(1'b1, 12'h004, 32'h5);
    apb(1'b1, 12'h008, 32'h3C);
    u_mach.set_auto(1'b0);
    u_mach.set_auto(1'b1);
    settle(3);
    check("mode stops", {31'h0, run}, 32'h0);
    u_mach.set_x(5, 1'b1);
    settle(3);
    check("run on input", {31'h0, run}, 32'h1);
    u_mach.set_x(60, 1'b1);
    settle(3);
    check("stop on input", {31'h0, run}, 32'h0);
    settle(5);
    check("held no restart", {31'h0, run}, 32'h0);
    u_mach.set_x(5, 1'b0);
    u_mach.set_auto(1'b0);
    u_mach.set_x(5, 1'b1);
    settle(3);
    check("no start in manual", {31'h0, run}, 32'h0);
    u_mach.set_x(5, 1'b0);
    u_mach.set_x(60, 1'b0);
    apb(1'b1, 12'h000, 32'h22);
    u_mach.set_auto(1'b0);
    u_mach.set_auto(1'b1);
    settle(3);
    check("start both mode", {31'h0, run}, 32'h1);
    $display("Done start stop");
  endtask
  task automatic t_error();
    apb(1'b1, 12'h010, 32'h3);
    apb(1'b1, 12'h000, 32'h22);
    u_mach.err_pulse();
    settle(3);
    check("err off", {31'h0, |y_out}, 32'h0);
    apb(1'b1, 12'h000, 32'h2A);
    u_mach.err_pulse();
    settle(3);
    check("err on", {31'h0, y_out[3]}, 32'h1);
    $display("Done error");
  endtask
  task automatic t_step();
    apb(1'b1, 12'h00C, 32'h9);
    u_mach.set_x(9, 1'b1);
    apb(1'b1, 12'h000, 32'h20);
    settle(3);
    check("chg0 input ignored", {31'h0, step}, 32'h0);
    apb(1'b1, 12'h024, 32'h1);
    settle(3);
    check("chg0 flag", {31'h0, step}, 32'h1);
    apb(1'b1, 12'h024, 32'h0);
    apb(1'b1, 12'h000, 32'h30);
    settle(3);
    check("chg1 input", {31'h0, step}, 32'h1);
    u_mach.set_x(9, 1'b0);
    settle(3);
    check("chg1 cycle", {31'h0, step}, 32'h0);
    $display("Done step");
  endtask
  task automatic t_conv(input logic [31:0] cfg, input logic [31:0] exp, input logic [31:0] st);
    int n;
    apb(1'b1, 12'h000, cfg);
    apb(1'b1, 12'h014, 32'hFA0);
    apb(1'b1, 12'h018, 32'h64);
    apb(1'b1, 12'h030, 32'h8);
    apb(1'b1, 12'h01C, 32'h64);
    n = 0;
    do begin
      apb(1'b0, 12'h028, 32'h0);
      n++;
    end while (rd[5] !== 1'b0 && n < 40);
    if (n >= 40) begin
      errors++;
      print_verdict();
    end
    check("unit status", rd & 32'h1C, st);
    apb(1'b0, 12'h020, 32'h0);
    check("pulses", rd, exp);
    settle(1);
    check("irq conv", {31'h0, irq}, 32'h1);
    apb(1'b1, 12'h02C, 32'hF);
    $display("Done conversion");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    t_start_stop();
    t_error();
    t_step();
    t_conv(32'h00, 32'h003D_0900, 32'h10);
    t_conv(32'h20, 32'h0000_0064, 32'h0C);
    t_conv(32'h40, 32'h003D_0900, 32'h18);
    print_verdict();
  end
endmodule // test_subtask_sequencer_unit_config
`default_nettype wire
